// *** core/memory_map_bank_decode.sv ***
`timescale 1ns/1ps
// Behaviour
// RL1: Program counter is 13 bits, addressing up to 8K words of 14 bits.
// RL2: Fetch above implemented program size wraps into implemented range.
// RL3: Any reset loads the program counter with 0000h.
// RL4: Taking an interrupt loads the program counter with 0004h.
// RL5: Branches take two cycles; the prefetched instruction is flushed.
// RL6: Status bits 6:5 select one of four data banks.
// RL7: Each bank spans 128 byte offsets, 00h to 7Fh.
// RL8: Low bank offsets decode to special registers, higher ones to RAM.
// RL9: Core special registers respond at the same offset in every bank.
// RL10: RAM reachable directly or through the indirect pointer.
// RL11: Smallest variant maps bank 1 offsets 8Ch-AFh onto bank 0 0Ch-2Fh.
// RL12: Offset 00h has no storage and acts on the pointed-to location.
// RL13: Instruction cycle is four phases of the clock; PC advances in phase one.
// RL14: Operand read in phase two, destination written in phase four.
// RL15: Unimplemented data locations read zero and ignore writes.
// RL16: Direct address is bank-select bits above the seven-bit offset.
module memory_map_bank_decode
  import memmap_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] variant,
  input wire data_req_s dreq,
  input wire flow_req_s freq,
  output logic [12:0] prog_addr,
  output logic fetch_valid,
  output logic [7:0] rdata,
  output logic [3:0] phase,
  output logic [7:0] core_status,
  output logic [7:0] indirect_pointer
);

  ////////////////////////////////////////////////////////////////////////
  // Phase generator and program counter.
  phase_e phase_r, phase_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic fetch_ok_r, fetch_ok_nxt;
  logic [12:0] pmask;

  // Wrapping is a mask, so high addresses alias low ones rather than fault.
  always_comb begin
    case (variant)
      VAR_1K: pmask = PMASK_1K;
      VAR_2K: pmask = PMASK_2K;
      VAR_4K: pmask = PMASK_4K;
      default: pmask = PMASK_8K;
    endcase
  end

  // Branch and interrupt requests are sampled in phase four only.
  always_comb begin
    phase_nxt = phase_r;
    pc_nxt = pc_r;
    fetch_ok_nxt = fetch_ok_r;
    case (phase_r)
      PH_ONE: phase_nxt = PH_TWO;
      PH_TWO: phase_nxt = PH_THREE;
      PH_THREE: phase_nxt = PH_FOUR;
      default: begin
        phase_nxt = PH_ONE; // see RL13
        fetch_ok_nxt = 1'b1;
        if (freq.irq) begin
          pc_nxt = INT_VEC & pmask; // see RL4
          fetch_ok_nxt = 1'b0; // see RL5
        end else if (freq.branch) begin
          pc_nxt = freq.target & pmask; // see RL2
          fetch_ok_nxt = 1'b0; // see RL5
        end else begin
          pc_nxt = (pc_r + 13'h0001) & pmask; // see RL1
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_r <= PH_ONE;
      pc_r <= RESET_VEC; // see RL3
      fetch_ok_r <= 1'b1;
    end else begin
      phase_r <= phase_nxt;
      pc_r <= pc_nxt;
      fetch_ok_r <= fetch_ok_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data side decode.
  logic [7:0] gpr [GPR_DEPTH];
  logic [7:0] status_r, status_nxt;
  logic [7:0] fsr_r, fsr_nxt;
  logic [7:0] program_counter_high_latch_r, program_counter_high_latch_nxt;
  logic [7:0] interrupt_control_r, interrupt_control_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [8:0] eff_addr;
  logic [6:0] eff_ofs;
  logic [1:0] eff_bank;
  logic gpr_hit, gpr_we;
  logic [8:0] gpr_idx;

  // Indirect access uses the pointer plus the high bank bit, as a 9-bit address.
  always_comb begin
    if (dreq.ofs == OFS_INDIRECT_DATA_PORT) begin
      eff_addr = {status_r[BANK_SEL_HIGH_BIT], fsr_r}; // see RL12, RL10
    end else begin
      eff_addr = {status_r[BANK_SEL_HIGH_BIT:BANK_SEL_LOW_BIT], dreq.ofs}; // see RL16, RL6
    end
    eff_ofs = eff_addr[6:0]; // see RL7
    eff_bank = eff_addr[8:7];
  end

  // Parts below 8K have no RAM in banks 2 and 3; only the 1K part aliases bank 1 RAM onto bank 0.
  always_comb begin
    gpr_idx = eff_addr;
    gpr_hit = eff_ofs >= GPR_LO; // see RL8
    if (variant == VAR_1K) begin
      gpr_hit = (eff_bank[1] == 1'b0) && eff_ofs >= SMALL_GPR_LO && eff_ofs <= SMALL_GPR_HI;
      gpr_idx = {2'h0, eff_ofs}; // see RL11
    end else if (variant != VAR_8K && eff_bank[1]) begin
      gpr_hit = 1'b0; // see RL15
    end
    gpr_we = gpr_hit && dreq.wr && phase_r == PH_FOUR; // see RL14
  end

  // Core registers ignore the bank bits so they appear in every bank.
  always_comb begin
    status_nxt = status_r;
    fsr_nxt = fsr_r;
    program_counter_high_latch_nxt = program_counter_high_latch_r;
    interrupt_control_nxt = interrupt_control_r;
    rdata_nxt = rdata_r;
    if (phase_r == PH_TWO && dreq.rd) begin
      rdata_nxt = 8'h00; // see RL15
      if (gpr_hit) begin
        rdata_nxt = gpr[gpr_idx]; // see RL14
      end else if (eff_ofs == OFS_PROGRAM_COUNTER_LOW) begin
        rdata_nxt = pc_r[7:0]; // see RL9
      end else if (eff_ofs == OFS_CORE_STATUS) begin
        rdata_nxt = status_r;
      end else if (eff_ofs == OFS_INDIRECT_POINTER) begin
        rdata_nxt = fsr_r;
      end else if (eff_ofs == OFS_PROGRAM_COUNTER_HIGH_LATCH) begin
        rdata_nxt = program_counter_high_latch_r;
      end else if (eff_ofs == OFS_INTERRUPT_CONTROL) begin
        rdata_nxt = interrupt_control_r;
      end
    end
    if (phase_r == PH_FOUR && dreq.wr) begin
      if (eff_ofs == OFS_CORE_STATUS) begin
        status_nxt = dreq.wdata; // see RL9
      end else if (eff_ofs == OFS_INDIRECT_POINTER) begin
        fsr_nxt = dreq.wdata;
      end else if (eff_ofs == OFS_PROGRAM_COUNTER_HIGH_LATCH) begin
        program_counter_high_latch_nxt = dreq.wdata;
      end else if (eff_ofs == OFS_INTERRUPT_CONTROL) begin
        interrupt_control_nxt = dreq.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_r <= STATUS_RESET;
      fsr_r <= REG_RESET;
      program_counter_high_latch_r <= REG_RESET;
      interrupt_control_r <= REG_RESET;
      rdata_r <= REG_RESET;
    end else begin
      status_r <= status_nxt;
      fsr_r <= fsr_nxt;
      program_counter_high_latch_r <= program_counter_high_latch_nxt;
      interrupt_control_r <= interrupt_control_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // RAM has no reset; software must initialise it.
  always_ff @(posedge clk) begin
    if (gpr_we) begin
      gpr[gpr_idx] <= dreq.wdata; // see RL10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.
  assign prog_addr = pc_r;
  assign fetch_valid = fetch_ok_r; // Kept as a valid flag so the port needs no inverter.
  assign rdata = rdata_r;
  assign phase = phase_r;
  assign core_status = status_r;
  assign indirect_pointer = fsr_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  a_reset_vector: assert property (@(posedge clk) srst |=> pc_r == RESET_VEC) // see RL3
    else $error("pc not at reset vector after reset");
  a_irq_vector: assert property (@(posedge clk) disable iff (srst)
    phase_r == PH_FOUR && freq.irq |=> pc_r == (INT_VEC & pmask)) // see RL4
    else $error("pc not at interrupt vector");
  a_branch_flush: assert property (@(posedge clk) disable iff (srst)
    phase_r == PH_FOUR && (freq.irq || freq.branch) |=> !fetch_valid [*4]) // see RL5
    else $error("fetch not flushed after branch");
  a_phase_cycle: assert property (@(posedge clk) disable iff (srst)
    phase_r == PH_ONE |=> phase_r == PH_TWO ##1 phase_r == PH_THREE ##1 phase_r == PH_FOUR) // see RL13
    else $error("phase sequence broken");
  a_pc_stable: assert property (@(posedge clk) disable iff (srst)
    phase_r != PH_FOUR |=> $stable(pc_r)) // see RL13
    else $error("pc moved outside phase four");
  a_pc_wraps: assert property (@(posedge clk) disable iff (srst)
    (pc_r & ~pmask) == 13'h0000 || $changed(variant)) // see RL2
    else $error("pc beyond implemented range");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (srst)
    phase_r == PH_TWO && dreq.rd && !gpr_hit && eff_ofs == GPR_LO |=> rdata == 8'h00) // see RL15
    else $error("unimplemented location read nonzero");
  a_status_write: assert property (@(posedge clk) disable iff (srst)
    phase_r == PH_FOUR && dreq.wr && dreq.ofs == OFS_CORE_STATUS |=> core_status == $past(dreq.wdata)) // see RL9
    else $error("status write lost");
  a_rdata_hold: assert property (@(posedge clk) disable iff (srst)
    phase_r != PH_TWO |=> $stable(rdata)) // see RL14
    else $error("read data changed outside phase two");

endmodule

// *** core/memmap_pkg.sv ***
package memmap_pkg;
  // Program side.
  localparam int PC_W = 13;
  localparam int WORD_W = 14;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  // Implemented program store sizes, as address masks.
  localparam logic [12:0] PMASK_1K = 13'h03ff;
  localparam logic [12:0] PMASK_2K = 13'h07ff;
  localparam logic [12:0] PMASK_4K = 13'h0fff;
  localparam logic [12:0] PMASK_8K = 13'h1fff;
  // Data side register offsets (in-bank).
  localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
  localparam logic [6:0] OFS_CORE_STATUS = 7'h03;
  localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0b;
  // General purpose window and the small-variant alias window.
  localparam logic [6:0] GPR_LO = 7'h20;
  localparam logic [6:0] SMALL_GPR_LO = 7'h0c;
  localparam logic [6:0] SMALL_GPR_HI = 7'h2f;
  // Status bank-select field.
  localparam int BANK_SEL_LOW_BIT = 5;
  localparam int BANK_SEL_HIGH_BIT = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int GPR_DEPTH = 512;
  // Variant codes.
  localparam logic [1:0] VAR_1K = 2'h0;
  localparam logic [1:0] VAR_2K = 2'h1;
  localparam logic [1:0] VAR_4K = 2'h2;
  localparam logic [1:0] VAR_8K = 2'h3;

  // One-hot phase of the instruction cycle.
  typedef enum logic [3:0] {
    PH_ONE = 4'b0001,
    PH_TWO = 4'b0010,
    PH_THREE = 4'b0100,
    PH_FOUR = 4'b1000
  } phase_e;

  // Data access request from the execute stage.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] ofs;
    logic [7:0] wdata;
  } data_req_s;

  // Program-flow request from the execute stage.
  typedef struct packed {
    logic branch;
    logic irq;
    logic [12:0] target;
  } flow_req_s;
endpackage

// *** testbench/exec_stage_model.sv ***
`timescale 1ns/1ps
// Stand-in for the execute stage: it presents data and flow requests in the phases the core uses.
module exec_stage_model
  import memmap_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] phase,
  output data_req_s dreq,
  output flow_req_s freq
);
  initial begin
    dreq = '0;
    freq = '0;
  end

  // The bound keeps a stuck phase counter from hanging the caller.
  task automatic wait_phase(input logic [3:0] want);
    for (int i = 0; i < 8 && phase !== want; i++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // A read is held through phase two and a write through phase four.
  task automatic access(input logic wr, input logic [6:0] ofs, input logic [7:0] wdata);
    wait_phase(wr ? PH_FOUR : PH_TWO);
    dreq = '{rd: !wr, wr: wr, ofs: ofs, wdata: wdata};
    @(posedge clk);
    #1;
    // Released lines show the inverse, so a stale value cannot pass for a held one.
    dreq = '{rd: 1'b0, wr: 1'b0, ofs: ~ofs, wdata: ~wdata};
  endtask

  // A flow change is only presented in phase four.
  task automatic flow(input logic irq, input logic [12:0] target);
    wait_phase(PH_FOUR);
    freq = '{branch: !irq, irq: irq, target: target};
    @(posedge clk);
    #1;
    freq = '{branch: 1'b0, irq: 1'b0, target: ~target};
  endtask
endmodule

// *** testbench/memory_map_bank_decode_tb_top.sv ***
`timescale 1ns/1ps
module memory_map_bank_decode_tb_top
  import memmap_pkg::*;
;
  logic clk;
  logic srst;
  logic [1:0] variant = VAR_4K;
  data_req_s dreq;
  flow_req_s freq;
  logic [12:0] prog_addr;
  logic fetch_valid;
  logic [7:0] rdata;
  logic [3:0] phase;
  logic [7:0] core_status;
  logic [7:0] indirect_pointer;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;

  memory_map_bank_decode u_dut (.clk(clk), .srst(srst), .variant(variant), .dreq(dreq), .freq(freq),
    .prog_addr(prog_addr), .fetch_valid(fetch_valid), .rdata(rdata), .phase(phase),
    .core_status(core_status), .indirect_pointer(indirect_pointer));
  exec_stage_model u_exec (.clk(clk), .phase(phase), .dreq(dreq), .freq(freq));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Values are widened to one size so a single compare serves data and addresses.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
    u_exec.access(1'b1, ofs, d);
  endtask
  task automatic rd(input logic [6:0] ofs, input logic [7:0] exp);
    u_exec.access(1'b0, ofs, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // The whole sequence needs about 110 cycles; the ceiling of 3000 leaves ample margin.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    srst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    chk(prog_addr, RESET_VEC);
    chk(phase, PH_ONE);
    chk(core_status, STATUS_RESET);
    chk(indirect_pointer, REG_RESET);
    chk(fetch_valid, 1'b1);
    // The same offset in bank 0 and bank 1 must hold separate bytes.
    wr(7'h20, 8'h5a);
    wr(OFS_CORE_STATUS, 8'h20);
    chk(core_status, 8'h20);
    wr(7'h20, 8'ha5);
    rd(7'h20, 8'ha5);
    rd(OFS_CORE_STATUS, 8'h20);
    // From bank 1 the pointer still reaches bank 0, since status bit 6 is clear.
    wr(OFS_INDIRECT_POINTER, 8'h20);
    chk(indirect_pointer, 8'h20);
    rd(OFS_INDIRECT_DATA_PORT, 8'h5a);
    wr(OFS_INDIRECT_DATA_PORT, 8'h3c);
    // Bank 2 has no RAM on this variant, but status still answers there.
    wr(OFS_CORE_STATUS, 8'h40);
    wr(7'h20, 8'h77);
    rd(7'h20, 8'h00);
    rd(OFS_CORE_STATUS, 8'h40);
    wr(OFS_CORE_STATUS, 8'h00);
    rd(7'h20, 8'h3c);
    // A target above the 4K store wraps, and so does the next advance.
    u_exec.flow(1'b0, 13'h1fff);
    chk(prog_addr, 13'h0fff);
    chk(fetch_valid, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk(prog_addr, 13'h0000);
    chk(fetch_valid, 1'b1);
    u_exec.flow(1'b1, 13'h0123);
    chk(prog_addr, INT_VEC);
    // A second reset in mid-run returns to the reset vector; the variant changes here while held in reset.
    srst = 1'b1;
    variant = VAR_1K;
    @(posedge clk);
    #1;
    srst = 1'b0;
    chk(prog_addr, RESET_VEC);
    // Smallest part: bank 1 RAM is bank 0 RAM, and RAM keeps its contents over reset.
    wr(OFS_CORE_STATUS, 8'h20);
    rd(7'h20, 8'h3c);
    wr(7'h0c, 8'h96);
    wr(OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h12);
    wr(OFS_INTERRUPT_CONTROL, 8'h34);
    // The counter low byte read from bank 1 is the target just loaded, wrapped into 1K.
    u_exec.flow(1'b0, 13'h1d55);
    chk(prog_addr, 13'h0155);
    rd(OFS_PROGRAM_COUNTER_LOW, 8'h55);
    wr(OFS_CORE_STATUS, 8'h00);
    rd(7'h0c, 8'h96);
    rd(7'h30, 8'h00);
    rd(OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h12);
    rd(OFS_INTERRUPT_CONTROL, 8'h34);
    // The largest part has RAM in bank 2 as well.
    variant = VAR_8K;
    wr(OFS_CORE_STATUS, 8'h40);
    wr(7'h20, 8'he1);
    rd(7'h20, 8'he1);
    final_report();
  end
endmodule
